// *** hdl/rqa_arbiter.v ***
/*
 * Request arbiter: priority registers, fast-request registers, pending view,
 * level arbitration, vector address and wake signalling.
 * Assumes request inputs and the register port are synchronous to REF_CLK
 * and that REF_CLK keeps running while the core sleeps.
 */
`timescale 1ns/1ps
`include "rqa_map.vh"

module rqa_arbiter #(
    parameter NSRC = 46,
    parameter VW = 6,
    parameter AW = 21
) (
    input wire REF_CLK,
    input wire RST,
    input wire [4:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [15:0] REG_RDATA,
    input wire [NSRC-1:0] IRQ_REQ,
    input wire LOW_POWER,
    output reg IRQ_VALID,
    output reg [1:0] IRQ_LEVEL,
    output reg [VW:0] IRQ_VECTOR,
    output reg [AW-1:0] IRQ_ADDR,
    output reg IRQ_FAST,
    output reg WAKE_REQ
);
    // ****************************************
    // Storage
    // ****************************************
    reg [15:0] prio_r [0:4];
    reg [15:0] vbase_r;
    reg [15:0] fmatch_a_r;
    reg [15:0] flow_a_r;
    reg [15:0] fhigh_a_r;
    reg [15:0] fmatch_b_r;
    reg [15:0] flow_b_r;
    reg [15:0] fhigh_b_r;
    reg dis_r;
    reg sleep_r;
    reg [NSRC-1:0] wake_en_r;
    reg [NSRC-1:0] req_r;

    wire [79:0] prio_all;
    wire [NSRC-1:0] src_en;
    wire [2*NSRC-1:0] src_lvl;
    wire [NSRC-1:0] act [0:3];
    wire [3:0] lvl_hit;
    wire [VW-1:0] lvl_idx [0:3];

    reg win_hit;
    reg [1:0] win_lvl;
    reg [VW-1:0] win_vec;
    reg [AW-1:0] addr_nxt;
    reg fast_nxt;
    reg [15:0] rd_nxt;
    integer k;
    integer j;

    assign prio_all = {prio_r[4], prio_r[3], prio_r[2], prio_r[1], prio_r[0]};

    // Writable-bit mask of one priority register
    function [15:0] prio_mask;
        input [2:0] n;
        begin
            if (n == 3'h0) begin
                prio_mask = `RQA_MASK_PRIO0;
            end else if (n == 3'h1) begin
                prio_mask = `RQA_MASK_PRIO1;
            end else if (n == 3'h2) begin
                prio_mask = `RQA_MASK_PRIO2;
            end else if (n == 3'h3) begin
                prio_mask = `RQA_MASK_PRIO3;
            end else begin
                prio_mask = `RQA_MASK_PRIO4;
            end
        end
    endfunction

    // Offset falls on one of the five priority registers
    function is_prio_ofs;
        input [4:0] a;
        begin
            is_prio_ofs = (a <= `RQA_OFS_PRIO4);
        end
    endfunction

    // Level-two winner whose vector equals a match register
    function fast_hit;
        input [1:0] lvl;
        input [VW-1:0] vec;
        input [15:0] match;
        begin
            fast_hit = (lvl == `RQA_FAST_LEVEL) && (vec == match[VW-1:0]);
        end
    endfunction

    // ****************************************
    // Per-source enable and level
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < NSRC; g = g + 1) begin : g_src
            if (g <= `RQA_FIX_SRC_LAST) begin : g_fix
                // Fixed sources always enabled at the top level
                assign src_en[g] = 1'b1;
                assign src_lvl[2*g +: 2] = `RQA_FIX_LEVEL;
            end else if (g <= `RQA_FIELD_SRC_LAST) begin : g_fld
                // Field 00 disables, 01..11 give levels 0..2
                assign src_en[g] = |prio_all[2*(g-2) +: 2];
                assign src_lvl[2*g +: 2] = prio_all[2*(g-2) +: 2] - 2'h1;
            end else begin : g_none
                // No priority field: source stays disabled
                assign src_en[g] = 1'b0;
                assign src_lvl[2*g +: 2] = 2'h0;
            end
        end
    endgenerate

    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lvl
            genvar s;
            for (s = 0; s < NSRC; s = s + 1) begin : g_act
                assign act[g][s] = req_r[s] & src_en[s] & (src_lvl[2*s +: 2] == g);
            end
            rqa_low_first #(
                .N(NSRC),
                .W(VW)
            ) u_enc (
                .act(act[g]),
                .hit(lvl_hit[g]),
                .idx(lvl_idx[g])
            );
        end
    endgenerate

    // ****************************************
    // Winner selection and vector address
    // ****************************************
    // highest level with a request wins
    always @* begin
        win_hit = 1'b0;
        win_lvl = 2'h0;
        win_vec = {VW{1'b0}};
        for (k = 0; k < 4; k = k + 1) begin
            if (lvl_hit[k]) begin
                win_hit = 1'b1;
                win_lvl = k[1:0];
                win_vec = lvl_idx[k];
            end
        end
    end

    // Fast match check, else base-relative address
    always @* begin
        fast_nxt = 1'b0;
        addr_nxt = {vbase_r[13:0], win_vec, 1'b0};
        if (fast_hit(win_lvl, win_vec, fmatch_a_r)) begin
            fast_nxt = 1'b1;
            addr_nxt = {fhigh_a_r[4:0], flow_a_r};
        end else if (fast_hit(win_lvl, win_vec, fmatch_b_r)) begin
            fast_nxt = 1'b1;
            addr_nxt = {fhigh_b_r[4:0], flow_b_r};
        end
    end

    // ****************************************
    // Pending and control read views
    // ****************************************
    // unused pending positions read one
    wire [15:0] pend_low_view;
    wire [15:0] pend_mid_view;
    wire [15:0] pend_high_view;
    wire [15:0] ctrl_view;

    assign pend_low_view = {req_r[`RQA_PENDL_TOP:`RQA_PENDL_BOT], 1'b0} | `RQA_PENDL_FILL;
    assign pend_mid_view = req_r[`RQA_PENDM_TOP:`RQA_PENDM_BOT];
    assign pend_high_view = {3'h0, req_r[`RQA_PENDH_TOP:`RQA_PENDH_BOT]} | `RQA_PENDH_FILL;
    // flag, level, vector, disable, fixed bits
    assign ctrl_view = {IRQ_VALID, IRQ_LEVEL, IRQ_VECTOR, dis_r, 5'h00} | `RQA_CTRL_FILL;

    // ****************************************
    // Read decode
    // ****************************************
    // offsets decoded within the module
    always @* begin
        rd_nxt = 16'h0000;
        if (is_prio_ofs(REG_ADDR)) begin
            // reserved bits already held at zero
            rd_nxt = prio_r[REG_ADDR[2:0]];
        end else if (REG_ADDR == `RQA_OFS_VBASE) begin
            rd_nxt = vbase_r;
        end else if (REG_ADDR == `RQA_OFS_FMA) begin
            rd_nxt = fmatch_a_r;
        end else if (REG_ADDR == `RQA_OFS_FLA) begin
            rd_nxt = flow_a_r;
        end else if (REG_ADDR == `RQA_OFS_FHA) begin
            rd_nxt = fhigh_a_r;
        end else if (REG_ADDR == `RQA_OFS_FMB) begin
            rd_nxt = fmatch_b_r;
        end else if (REG_ADDR == `RQA_OFS_FLB) begin
            rd_nxt = flow_b_r;
        end else if (REG_ADDR == `RQA_OFS_FHB) begin
            rd_nxt = fhigh_b_r;
        end else if (REG_ADDR == `RQA_OFS_PENDL) begin
            // sources 16..2, bit 0 reads one
            rd_nxt = pend_low_view;
        end else if (REG_ADDR == `RQA_OFS_PENDM) begin
            rd_nxt = pend_mid_view;
        end else if (REG_ADDR == `RQA_OFS_PENDH) begin
            rd_nxt = pend_high_view;
        end else if (REG_ADDR == `RQA_OFS_CTRL) begin
            // flag, level, vector, disable, fixed bits
            rd_nxt = ctrl_view;
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    // cleared registers leave only fixed sources 0 and 1 enabled
    always @(posedge REF_CLK) begin
        if (RST) begin
            for (j = 0; j < 5; j = j + 1) begin
                prio_r[j] <= `RQA_RST_WORD;
            end
            vbase_r <= `RQA_RST_WORD;
            fmatch_a_r <= `RQA_RST_WORD;
            flow_a_r <= `RQA_RST_WORD;
            fhigh_a_r <= `RQA_RST_WORD;
            fmatch_b_r <= `RQA_RST_WORD;
            flow_b_r <= `RQA_RST_WORD;
            fhigh_b_r <= `RQA_RST_WORD;
            dis_r <= 1'b0;
        end else if (REG_WR) begin
            if (is_prio_ofs(REG_ADDR)) begin
                prio_r[REG_ADDR[2:0]] <= REG_WDATA & prio_mask(REG_ADDR[2:0]);
            end else if (REG_ADDR == `RQA_OFS_VBASE) begin
                vbase_r <= REG_WDATA & `RQA_MASK_VBASE;
            end else if (REG_ADDR == `RQA_OFS_FMA) begin
                fmatch_a_r <= REG_WDATA & `RQA_MASK_FMATCH;
            end else if (REG_ADDR == `RQA_OFS_FLA) begin
                flow_a_r <= REG_WDATA;
            end else if (REG_ADDR == `RQA_OFS_FHA) begin
                fhigh_a_r <= REG_WDATA & `RQA_MASK_FHIGH;
            end else if (REG_ADDR == `RQA_OFS_FMB) begin
                fmatch_b_r <= REG_WDATA & `RQA_MASK_FMATCH;
            end else if (REG_ADDR == `RQA_OFS_FLB) begin
                flow_b_r <= REG_WDATA;
            end else if (REG_ADDR == `RQA_OFS_FHB) begin
                fhigh_b_r <= REG_WDATA & `RQA_MASK_FHIGH;
            end else if (REG_ADDR == `RQA_OFS_CTRL) begin
                dis_r <= REG_WDATA[`RQA_CTRL_DIS_BIT];
            end
        end
    end

    // ****************************************
    // Read port, request sampling, outputs
    // ****************************************
    // Read data held until next read
    always @(posedge REF_CLK) begin
        if (RST) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            REG_RDATA <= rd_nxt;
        end
    end

    // Sample requests, present winner to core
    always @(posedge REF_CLK) begin
        if (RST) begin
            req_r <= {NSRC{1'b0}};
            IRQ_VALID <= 1'b0;
            IRQ_LEVEL <= 2'h0;
            IRQ_VECTOR <= {(VW+1){1'b0}};
            IRQ_ADDR <= {AW{1'b0}};
            IRQ_FAST <= 1'b0;
        end else begin
            req_r <= IRQ_REQ;
            // Global disable holds off presentation only
            IRQ_VALID <= win_hit & ~dis_r;
            IRQ_LEVEL <= win_lvl;
            IRQ_VECTOR <= {1'b0, win_vec};
            IRQ_ADDR <= addr_nxt;
            IRQ_FAST <= fast_nxt;
        end
    end

    // ****************************************
    // Sleep wake-up
    // ****************************************
    // Sleep entry is the first cycle LOW_POWER is seen high
    wire sleep_entry;
    assign sleep_entry = LOW_POWER & ~sleep_r;

    // Any pending request enabled at sleep entry
    wire wake_hit;
    assign wake_hit = |(req_r & wake_en_r);

    // Enables frozen on entry to sleep
    always @(posedge REF_CLK) begin
        if (RST) begin
            sleep_r <= 1'b0;
            wake_en_r <= {NSRC{1'b0}};
            WAKE_REQ <= 1'b0;
        end else begin
            sleep_r <= LOW_POWER;
            if (sleep_entry) begin
                wake_en_r <= src_en;
            end
            WAKE_REQ <= LOW_POWER & sleep_r & wake_hit;
        end
    end
endmodule

// *** hdl/rqa_low_first.v ***
/*
 * Lowest-index-first encoder for one priority level.
 * Assumes a purely combinational use inside the arbiter.
 */
`timescale 1ns/1ps
module rqa_low_first #(
    parameter N = 46,
    parameter W = 6
) (
    input wire [N-1:0] act,
    output reg hit,
    output reg [W-1:0] idx
);
    integer i;

    // ****************************************
    // Scan from the top so the lowest active index ends winning
    // ****************************************
    always @* begin
        hit = 1'b0;
        idx = {W{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (act[i]) begin
                hit = 1'b1;
                idx = i[W-1:0];
            end
        end
    end
endmodule

// *** shared/rqa_map.vh ***
/*
 * Register offsets, field positions, read masks and reset values of the
 * request arbiter. Definitions only; included by the arbiter module.
 */
`ifndef RQA_MAP_VH
`define RQA_MAP_VH

// ****************************************
// Register offsets (word index)
// ****************************************
`define RQA_OFS_PRIO0 5'h00
`define RQA_OFS_PRIO1 5'h01
`define RQA_OFS_PRIO2 5'h02
`define RQA_OFS_PRIO3 5'h03
`define RQA_OFS_PRIO4 5'h04
`define RQA_OFS_VBASE 5'h05
`define RQA_OFS_FMA 5'h06
`define RQA_OFS_FLA 5'h07
`define RQA_OFS_FHA 5'h08
`define RQA_OFS_FMB 5'h09
`define RQA_OFS_FLB 5'h0a
`define RQA_OFS_FHB 5'h0b
`define RQA_OFS_PENDL 5'h0c
`define RQA_OFS_PENDM 5'h0d
`define RQA_OFS_PENDH 5'h0e
`define RQA_OFS_CTRL 5'h12

// ****************************************
// Writable bit masks, reserved bits read zero
// ****************************************
`define RQA_MASK_PRIO0 16'hc3ff
`define RQA_MASK_PRIO1 16'hfcff
`define RQA_MASK_PRIO2 16'hf3ff
`define RQA_MASK_PRIO3 16'hfff0
`define RQA_MASK_PRIO4 16'h00ff
`define RQA_MASK_VBASE 16'h3fff
`define RQA_MASK_FMATCH 16'h003f
`define RQA_MASK_FHIGH 16'h001f
`define RQA_RST_WORD 16'h0000

// ****************************************
// Pending and control register layout, source ranges and levels
// ****************************************
`define RQA_PENDL_FILL 16'h0001
`define RQA_PENDH_FILL 16'he000
`define RQA_CTRL_FILL 16'h001c
`define RQA_CTRL_DIS_BIT 5
`define RQA_FIX_SRC_LAST 1
`define RQA_FIELD_SRC_LAST 41
`define RQA_FIX_LEVEL 2'h3
`define RQA_FAST_LEVEL 2'h2
`define RQA_PENDL_TOP 16
`define RQA_PENDL_BOT 2
`define RQA_PENDM_TOP 32
`define RQA_PENDM_BOT 17
`define RQA_PENDH_TOP 45
`define RQA_PENDH_BOT 33

`endif

// *** testbench/rqa_arbiter_bench.sv ***
/* Self-checking bench for the request arbiter.
   Assumes the arbiter, its checker and the core model are compiled first. */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module rqa_arbiter_bench;
    reg REF_CLK, RST, REG_WR, REG_RD, sleep_cmd;
    reg [4:0] REG_ADDR;
    reg [15:0] REG_WDATA;
    reg [45:0] IRQ_REQ;
    reg [1:0] mask;
    wire [15:0] REG_RDATA;
    wire LOW_POWER, IRQ_VALID, IRQ_FAST, WAKE_REQ, taken;
    wire [1:0] IRQ_LEVEL;
    wire [6:0] IRQ_VECTOR;
    wire [20:0] IRQ_ADDR;
    integer fails, compares, i;
    rqa_arbiter dut_u (.REF_CLK(REF_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .IRQ_REQ(IRQ_REQ), .LOW_POWER(LOW_POWER), .IRQ_VALID(IRQ_VALID),
        .IRQ_LEVEL(IRQ_LEVEL), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_ADDR(IRQ_ADDR),
        .IRQ_FAST(IRQ_FAST), .WAKE_REQ(WAKE_REQ));
    rqa_core_model core_u (.clk(REF_CLK), .rst(RST), .sleep_cmd(sleep_cmd),
        .core_status_mask(mask), .irq_valid(IRQ_VALID), .irq_level(IRQ_LEVEL),
        .wake_req(WAKE_REQ), .low_power_r(LOW_POWER), .taken(taken));
    // ****************************************
    // Register port and request tasks
    // ****************************************
    task wr(input [4:0] a, input [15:0] v);
        begin
            @(negedge REF_CLK);
            REG_ADDR = a;
            REG_WDATA = v;
            REG_WR = 1'b1;
            @(negedge REF_CLK);
            REG_WR = 1'b0;
        end
    endtask
    task chk_rd(input [4:0] a, input [15:0] e);
        begin
            @(negedge REF_CLK);
            REG_ADDR = a;
            REG_RD = 1'b1;
            @(negedge REF_CLK);
            REG_RD = 1'b0;
            `CHK(REG_RDATA, e)
        end
    endtask
    task req(input [45:0] r);
        begin
            @(negedge REF_CLK);
            IRQ_REQ = r;
            repeat (3) @(negedge REF_CLK);
        end
    endtask
    task chk_out(input v, input [1:0] l, input [6:0] n, input [20:0] a, input f);
        `CHK({IRQ_VALID, IRQ_LEVEL, IRQ_VECTOR, IRQ_ADDR, IRQ_FAST}, {v, l, n, a, f})
    endtask
    // Readable bits after writing all ones
    function [15:0] wmask(input [4:0] a);
        case (a)
            5'h00: wmask = 16'hc3ff;
            5'h01: wmask = 16'hfcff;
            5'h02: wmask = 16'hf3ff;
            5'h03: wmask = 16'hfff0;
            5'h04: wmask = 16'h00ff;
            5'h05: wmask = 16'h3fff;
            5'h06, 5'h09: wmask = 16'h003f;
            5'h07, 5'h0a: wmask = 16'hffff;
            5'h08, 5'h0b: wmask = 16'h001f;
            5'h0c: wmask = 16'h0001;
            5'h0e: wmask = 16'he000;
            5'h12: wmask = 16'h003c;
            default: wmask = 16'h0000;
        endcase
    endfunction
    task finish_test;
        begin
            if (fails == 0 && compares > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    // Clock
    initial begin
        REF_CLK = 1'b0;
        forever #12.5 REF_CLK = ~REF_CLK;
    end
    // Watchdog
    initial begin
        #(25 * 3000);
        fails++;
        finish_test;
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        fails = 0;
        compares = 0;
        RST = 1'b1;
        REG_ADDR = 5'h00;
        REG_WDATA = 16'h0000;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        IRQ_REQ = 46'h0;
        sleep_cmd = 1'b0;
        mask = 2'h0;
        repeat (10) @(negedge REF_CLK);
        RST = 1'b0;
        for (i = 0; i < 32; i++) chk_rd(i[4:0], wmask(i[4:0])
            & ((i == 12 || i == 14 || i == 18) ? 16'he01d : 16'h0000));
        for (i = 0; i < 32; i++) wr(i[4:0], 16'hffff);
        for (i = 0; i < 32; i++) chk_rd(i[4:0], wmask(i[4:0]));
        wr(5'h12, 16'h0000);
        wr(5'h05, 16'h0155);
        req(46'h1080);
        chk_out(1'b1, 2'h2, 7'd12, {14'h0155, 6'd12, 1'b0}, 1'b0);
        wr(5'h06, 16'h000c);
        wr(5'h07, 16'h1234);
        wr(5'h08, 16'h0015);
        req(46'h1080);
        chk_out(1'b1, 2'h2, 7'd12, 21'h151234, 1'b1);
        wr(5'h06, 16'h000d);
        wr(5'h09, 16'h000c);
        wr(5'h0a, 16'habcd);
        wr(5'h0b, 16'h000a);
        req(46'h1080);
        chk_out(1'b1, 2'h2, 7'd12, 21'h0aabcd, 1'b1);
        for (i = 0; i < 4; i++) begin
            mask = i[1:0];
            @(negedge REF_CLK);
            `CHK(taken, i < 3)
        end
        wr(5'h01, 16'hffdf);
        req(46'h101000);
        chk_out(1'b1, 2'h2, 7'd20, {14'h0155, 6'd20, 1'b0}, 1'b0);
        req(46'h101001);
        chk_out(1'b1, 2'h3, 7'd0, {14'h0155, 7'h00}, 1'b0);
        wr(5'h12, 16'h0020);
        req(46'h200000001001);
        chk_out(1'b0, 2'h3, 7'd0, {14'h0155, 7'h00}, 1'b0);
        chk_rd(5'h12, 16'h603c);
        chk_rd(5'h0c, 16'h0801);
        chk_rd(5'h0d, 16'h0000);
        chk_rd(5'h0e, 16'hf000);
        wr(5'h01, 16'h0000);
        req(46'h0);
        // Held over two falling edges so the model surely sees it
        sleep_cmd = 1'b1;
        repeat (2) @(negedge REF_CLK);
        sleep_cmd = 1'b0;
        repeat (3) @(negedge REF_CLK);
        wr(5'h01, 16'hffff);
        req(46'h1000);
        `CHK({WAKE_REQ, LOW_POWER}, 2'b01)
        req(46'h1001);
        `CHK(LOW_POWER, 1'b0)
        // Mid-run reset clears outputs and configuration
        RST = 1'b1;
        repeat (2) @(negedge REF_CLK);
        RST = 1'b0;
        chk_out(1'b0, 2'h0, 7'd0, 21'h0, 1'b0);
        chk_rd(5'h05, 16'h0000);
        finish_test;
    end
endmodule

// *** testbench/rqa_arbiter_properties.sv ***
/* Port checker for the request arbiter.
   Assumes one clock REF_CLK and synchronous active-high RST. */
`timescale 1ns/1ps
module rqa_arb_checker #(
    parameter NSRC = 46,
    parameter VW = 6,
    parameter AW = 21
) (
    input wire REF_CLK,
    input wire RST,
    input wire [4:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire [15:0] REG_RDATA,
    input wire [NSRC-1:0] IRQ_REQ,
    input wire LOW_POWER,
    input wire IRQ_VALID,
    input wire [1:0] IRQ_LEVEL,
    input wire [VW:0] IRQ_VECTOR,
    input wire [AW-1:0] IRQ_ADDR,
    input wire IRQ_FAST,
    input wire WAKE_REQ
);
    // ****************************************
    // Clocking and sequences
    // ****************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    sequence s_asleep;
        LOW_POWER [*3];
    endsequence
    sequence s_top_req;
        IRQ_REQ[0] ##1 (IRQ_REQ[0] && LOW_POWER);
    endsequence
    // ****************************************
    // Properties
    // ****************************************
    property p_wake;
        s_asleep ##0 s_top_req |=> WAKE_REQ;
    endproperty
    property p_wake_cause;
        WAKE_REQ |-> $past(LOW_POWER) && ($past(IRQ_REQ, 2) != 0);
    endproperty
    property p_fixed_top;
        IRQ_REQ[0] |-> ##2 (IRQ_VECTOR == 7'h00 && IRQ_LEVEL == 2'h3);
    endproperty
    property p_valid_cause;
        IRQ_VALID |-> $past(IRQ_REQ, 2) != 0;
    endproperty
    property p_normal_addr;
        IRQ_VALID && !IRQ_FAST |-> IRQ_ADDR[6:0] == {IRQ_VECTOR[5:0], 1'b0};
    endproperty
    property p_fast_level;
        IRQ_FAST |-> IRQ_LEVEL == 2'h2;
    endproperty
    property p_pend_low;
        REG_RD && REG_ADDR == 5'h0c |=> REG_RDATA == {$past(IRQ_REQ[16:2], 2), 1'b1};
    endproperty
    property p_pend_high;
        REG_RD && REG_ADDR == 5'h0e |=> REG_RDATA == {3'h7, $past(IRQ_REQ[45:33], 2)};
    endproperty
    property p_ctrl;
        REG_RD && REG_ADDR == 5'h12 |=> REG_RDATA[15] == $past(IRQ_VALID)
            && REG_RDATA[12:6] == $past(IRQ_VECTOR) && REG_RDATA[4:0] == 5'h1c;
    endproperty
    property p_rsvd;
        REG_RD && (REG_ADDR inside {[5'h0f:5'h11], [5'h13:5'h1f]}) |=> REG_RDATA == 16'h0000;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake in sleep");
    a_wake_cause: assert property (p_wake_cause) else $error("wake without cause");
    a_fixed_top: assert property (p_fixed_top) else $error("source 0 lost");
    a_valid_cause: assert property (p_valid_cause) else $error("valid without request");
    a_normal_addr: assert property (p_normal_addr) else $error("bad vector address");
    a_fast_level: assert property (p_fast_level) else $error("fast not level 2");
    a_pend_low: assert property (p_pend_low) else $error("pending low wrong");
    a_pend_high: assert property (p_pend_high) else $error("pending high wrong");
    a_ctrl: assert property (p_ctrl) else $error("control read wrong");
    a_rsvd: assert property (p_rsvd) else $error("reserved not zero");
endmodule

bind rqa_arbiter rqa_arb_checker #(.NSRC(NSRC), .VW(VW), .AW(AW)) chk_u (
    .REF_CLK(REF_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ_REQ(IRQ_REQ),
    .LOW_POWER(LOW_POWER), .IRQ_VALID(IRQ_VALID), .IRQ_LEVEL(IRQ_LEVEL),
    .IRQ_VECTOR(IRQ_VECTOR), .IRQ_ADDR(IRQ_ADDR), .IRQ_FAST(IRQ_FAST), .WAKE_REQ(WAKE_REQ));

// *** testbench/rqa_core_model.sv ***
/* Core and clock-control stand-in facing the request arbiter.
   Assumes the shared clock; drives low_power_r at the falling edge, taken combinationally. */
`timescale 1ns/1ps
module rqa_core_model (
    input wire clk,
    input wire rst,
    input wire sleep_cmd,
    input wire [1:0] core_status_mask,
    input wire irq_valid,
    input wire [1:0] irq_level,
    input wire wake_req,
    output reg low_power_r,
    output wire taken
);
    assign taken = irq_valid && (irq_level >= core_status_mask);
    always @(negedge clk) begin
        if (rst || wake_req) begin
            low_power_r <= 1'b0;
        end else if (sleep_cmd) begin
            low_power_r <= 1'b1;
        end
    end
endmodule
